/* logic/prg_regs.vh */
// register map, field positions, reset values and timing constants of the pulse generator
`ifndef PRG_REGS_VH
`define PRG_REGS_VH

// register byte offsets
`define PRG_OFF_CTRL      8'h00
`define PRG_OFF_DIV       8'h04
`define PRG_OFF_CYCLE     8'h08
`define PRG_OFF_DUTY      8'h0c
`define PRG_OFF_PATTERN   8'h10
`define PRG_OFF_STATUS    8'h14
`define PRG_OFF_IMASK     8'h18
`define PRG_OFF_STATE     8'h1c

// control register fields
`define PRG_CTRL_EN       0
`define PRG_CTRL_SRC      1
`define PRG_CTRL_POL      2
`define PRG_CTRL_MLVL     3
`define PRG_CTRL_RHY      4
`define PRG_CTRL_W        5

// state register fields
`define PRG_ST_STEP_LSB   0
`define PRG_ST_STEP_MSB   4
`define PRG_ST_LEVEL      8

// widths
`define PRG_DIV_W         12
`define PRG_DUTY_W        13
`define PRG_PAT_W         20
`define PRG_STEP_W        5

// reset values
`define PRG_CTRL_RST      5'h00
`define PRG_DIV_RST       12'h000
`define PRG_CYCLE_RST     12'hfff
`define PRG_DUTY_RST      13'h0000
`define PRG_PAT_RST       20'hfffff
`define PRG_IMASK_RST     1'h0

// rhythm timing: twenty steps of fifty milliseconds at a 125 MHz clock
`define PRG_STEP_MS       50
`define PRG_CLK_KHZ       125000
`define PRG_STEP_CYCLES   (`PRG_STEP_MS * `PRG_CLK_KHZ)
`define PRG_STEPS         20
`define PRG_LAST_STEP     5'h13
`define PRG_FIRST_STEP    5'h00

`endif

/* logic/prg_rhythm.v */
// rhythm counter: twenty 50 ms steps counting down, one pulse per 1 s period
`timescale 1ns/1ps
`include "prg_regs.vh"
module prg_rhythm #(
    parameter STEP_CYCLES = `PRG_STEP_CYCLES
) (
    input  wire                    clk_in,
    input  wire                    rstn_in,
    input  wire                    run_in,
    output wire [`PRG_STEP_W-1:0]  step_out,
    output wire                    period_out
);

    reg  [31:0]             tick_cnt_r;
    reg  [`PRG_STEP_W-1:0]  step_r;
    reg                     period_r;
    wire                    step_done;

    assign step_done  = run_in && (tick_cnt_r == STEP_CYCLES - 1);
    assign step_out   = step_r;
    assign period_out = period_r;

    // free of the pulse timer: its own prescale from the system clock
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tick_cnt_r <= 32'h0000_0000;
            step_r     <= `PRG_LAST_STEP;
            period_r   <= 1'b0;
        end
        else if (!run_in)
        begin
            // stopped counter restarts a whole period from the first step
            tick_cnt_r <= 32'h0000_0000;
            step_r     <= `PRG_LAST_STEP;
            period_r   <= 1'b0;
        end
        else
        begin
            period_r <= 1'b0;
            if (step_done)
            begin
                tick_cnt_r <= 32'h0000_0000;
                if (step_r == `PRG_FIRST_STEP)
                begin
                    step_r   <= `PRG_LAST_STEP;
                    period_r <= 1'b1;
                end
                else
                begin
                    step_r <= step_r - 5'h01;
                end
            end
            else
            begin
                tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            end
        end
    end

endmodule // prg_rhythm

/* logic/prg_top.v */
// pulse-width generator with rhythm masking, APB register slave and interrupt
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "prg_regs.vh"
module prg_top #(
    parameter STEP_CYCLES = `PRG_STEP_CYCLES
) (
    input  wire        MCLK_IN,
    input  wire        RSTN_IN,
    input  wire        SRC_FAST_IN,
    input  wire        SRC_SLOW_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output wire [31:0] PRDATA_OUT,
    output wire        PREADY_OUT,
    output wire        PSLVERR_OUT,
    output wire        PWM_OUT,
    output wire        IRQ_OUT
);

    // software registers
    reg  [`PRG_CTRL_W-1:0]  ctrl_r;
    reg  [`PRG_DIV_W-1:0]   div_r;
    reg  [`PRG_DIV_W-1:0]   cycle_r;
    reg  [`PRG_DUTY_W-1:0]  duty_r;
    reg  [`PRG_PAT_W-1:0]   pattern_r;
    reg                     status_r;
    reg                     imask_r;
    reg  [31:0]             prdata_r;

    // timing state
    reg                     fast_q_r;
    reg                     slow_q_r;
    reg  [`PRG_DIV_W-1:0]   pre_cnt_r;
    reg  [`PRG_DIV_W-1:0]   cyc_cnt_r;
    reg                     pwm_r;

    wire                    setup_ph;
    wire                    access_ph;
    wire                    wr_acc;
    wire                    rd_acc;
    wire                    mapped;
    wire                    src_edge;
    wire                    div_tick;
    wire                    active;
    wire                    masked;
    wire                    pwm_nxt;
    wire                    period_evt;
    wire [`PRG_STEP_W-1:0]  step;
    reg  [31:0]             rd_mux;

    wire en     = ctrl_r[`PRG_CTRL_EN];
    wire src    = ctrl_r[`PRG_CTRL_SRC];
    wire pol    = ctrl_r[`PRG_CTRL_POL];
    wire mlvl   = ctrl_r[`PRG_CTRL_MLVL];
    wire rhy_en = ctrl_r[`PRG_CTRL_RHY];

    // address decode shared by the write path, read mux and error answer
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    assign setup_ph  = PSEL_IN && !PENABLE_IN;
    assign access_ph = PSEL_IN && PENABLE_IN;
    assign wr_acc    = access_ph && PWRITE_IN;
    assign rd_acc    = access_ph && !PWRITE_IN;
    assign mapped    = hit(PADDR_IN, `PRG_OFF_CTRL)    || hit(PADDR_IN, `PRG_OFF_DIV)
                    || hit(PADDR_IN, `PRG_OFF_CYCLE)   || hit(PADDR_IN, `PRG_OFF_DUTY)
                    || hit(PADDR_IN, `PRG_OFF_PATTERN) || hit(PADDR_IN, `PRG_OFF_STATUS)
                    || hit(PADDR_IN, `PRG_OFF_IMASK)   || hit(PADDR_IN, `PRG_OFF_STATE);

    // every access completes in its first access cycle
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = access_ph && !mapped;
    assign PRDATA_OUT  = prdata_r;
    assign IRQ_OUT     = status_r && imask_r;
    assign PWM_OUT     = pwm_r;

    // register writes; an unmapped write is dropped and flagged by pslverr
    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            ctrl_r    <= `PRG_CTRL_RST;
            div_r     <= `PRG_DIV_RST;
            cycle_r   <= `PRG_CYCLE_RST;
            duty_r    <= `PRG_DUTY_RST;
            pattern_r <= `PRG_PAT_RST;
            imask_r   <= `PRG_IMASK_RST;
        end
        else if (wr_acc)
        begin
            if (hit(PADDR_IN, `PRG_OFF_CTRL))
                ctrl_r <= PWDATA_IN[`PRG_CTRL_W-1:0];
            if (hit(PADDR_IN, `PRG_OFF_DIV))
                div_r <= PWDATA_IN[`PRG_DIV_W-1:0];
            if (hit(PADDR_IN, `PRG_OFF_CYCLE))
                cycle_r <= PWDATA_IN[`PRG_DIV_W-1:0];
            if (hit(PADDR_IN, `PRG_OFF_DUTY))
                duty_r <= PWDATA_IN[`PRG_DUTY_W-1:0];
            if (hit(PADDR_IN, `PRG_OFF_PATTERN))
                pattern_r <= PWDATA_IN[`PRG_PAT_W-1:0];
            if (hit(PADDR_IN, `PRG_OFF_IMASK))
                imask_r <= PWDATA_IN[0];
        end
    end

    // read data is captured in the setup cycle so it stands through the access
    always @*
    begin
        rd_mux = 32'h0000_0000;
        if (hit(PADDR_IN, `PRG_OFF_CTRL))
            rd_mux[`PRG_CTRL_W-1:0] = ctrl_r;
        if (hit(PADDR_IN, `PRG_OFF_DIV))
            rd_mux[`PRG_DIV_W-1:0] = div_r;
        if (hit(PADDR_IN, `PRG_OFF_CYCLE))
            rd_mux[`PRG_DIV_W-1:0] = cycle_r;
        if (hit(PADDR_IN, `PRG_OFF_DUTY))
            rd_mux[`PRG_DUTY_W-1:0] = duty_r;
        if (hit(PADDR_IN, `PRG_OFF_PATTERN))
            rd_mux[`PRG_PAT_W-1:0] = pattern_r;
        if (hit(PADDR_IN, `PRG_OFF_STATUS))
            rd_mux[0] = status_r;
        if (hit(PADDR_IN, `PRG_OFF_IMASK))
            rd_mux[0] = imask_r;
        if (hit(PADDR_IN, `PRG_OFF_STATE))
        begin
            rd_mux[`PRG_ST_STEP_MSB:`PRG_ST_STEP_LSB] = step;
            rd_mux[`PRG_ST_LEVEL] = pwm_r;
        end
    end

    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            prdata_r <= 32'h0000_0000;
        else if (setup_ph && !PWRITE_IN)
            prdata_r <= rd_mux;
    end

    // sticky period flag; the read clears only what it returned, so an event
    // landing during the read survives into the next read
    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            status_r <= 1'b0;
        else if (period_evt)
            status_r <= 1'b1;
        else if (rd_acc && hit(PADDR_IN, `PRG_OFF_STATUS) && prdata_r[0])
            status_r <= 1'b0;
    end

    // source clocks arrive as levels synchronous to the system clock; only
    // their rising edges advance the prescaler, so 62.5 MHz is the fastest source
    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            fast_q_r <= 1'b0;
            slow_q_r <= 1'b0;
        end
        else
        begin
            fast_q_r <= SRC_FAST_IN;
            slow_q_r <= SRC_SLOW_IN;
        end
    end

    assign src_edge = src ? (SRC_SLOW_IN && !slow_q_r)
                          : (SRC_FAST_IN && !fast_q_r);

    // prescaler divides by div_r + 1, i.e. 1 through 4096
    assign div_tick = en && src_edge && (pre_cnt_r == div_r);

    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            pre_cnt_r <= `PRG_DIV_RST;
        else if (!en)
            pre_cnt_r <= `PRG_DIV_RST;
        else if (src_edge)
        begin
            if (pre_cnt_r >= div_r)
                pre_cnt_r <= `PRG_DIV_RST;
            else
                pre_cnt_r <= pre_cnt_r + 12'h001;
        end
    end

    // cycle counter: cycle_r + 1 divided ticks per pulse period, so with the
    // prescaler at one a setting of 1 gives source/2 and 4095 gives source/4096
    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            cyc_cnt_r <= `PRG_DIV_RST;
        else if (!en)
            cyc_cnt_r <= `PRG_DIV_RST;
        else if (div_tick)
        begin
            if (cyc_cnt_r >= cycle_r)
                cyc_cnt_r <= `PRG_DIV_RST;
            else
                cyc_cnt_r <= cyc_cnt_r + 12'h001;
        end
    end

    // duty of zero never activates; duty above the cycle length always does
    assign active = en && ({1'b0, cyc_cnt_r} < duty_r);

    prg_rhythm #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_rhythm (
        .clk_in      (MCLK_IN),
        .rstn_in     (RSTN_IN),
        .run_in      (rhy_en),
        .step_out    (step),
        .period_out  (period_evt)
    );

    assign masked  = rhy_en && !pattern_r[step];
    assign pwm_nxt = masked ? mlvl
                            : (pol ? active : !active);

    // registered pin: one clock of latency buys a glitch-free output
    always @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            pwm_r <= 1'b1;
        else
            pwm_r <= pwm_nxt;
    end

endmodule // prg_top

/* dv/prg_checker.sv */
// assertions on the pulse generator's bus, interrupt and output ports
`timescale 1ns/1ps
`include "prg_regs.vh"
module prg_checker #(
    parameter STEP_CYCLES = 20
) (
    input wire        MCLK_IN,
    input wire        RSTN_IN,
    input wire        PSEL_IN,
    input wire        PENABLE_IN,
    input wire        PWRITE_IN,
    input wire [7:0]  PADDR_IN,
    input wire [31:0] PRDATA_OUT,
    input wire        PSLVERR_OUT,
    input wire        PWM_OUT,
    input wire        IRQ_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    wire acc = PSEL_IN && PENABLE_IN;
    wire rd  = acc && !PWRITE_IN;
    // any access to status or mask may legally drop the interrupt
    wire clr = acc && (PADDR_IN == `PRG_OFF_STATUS || PADDR_IN == `PRG_OFF_IMASK);
    property p_err_phase; PSLVERR_OUT |-> acc; endproperty
    property p_err_unmap; rd && PADDR_IN > 8'h1c |-> PSLVERR_OUT && PRDATA_OUT == 32'h0; endproperty
    property p_rd_hold; !$past(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |-> $stable(PRDATA_OUT); endproperty
    property p_ctrl_hi; rd && PADDR_IN == `PRG_OFF_CTRL |-> PRDATA_OUT[31:5] == 27'h0; endproperty
    property p_lvl; rd && PADDR_IN == `PRG_OFF_STATE |-> PRDATA_OUT[8] == $past(PWM_OUT); endproperty
    property p_irq_fall; $fell(IRQ_OUT) |-> $past(clr); endproperty
    property p_irq_hold; IRQ_OUT && !clr |=> IRQ_OUT; endproperty
    property p_pwm_rst; $rose(RSTN_IN) |-> PWM_OUT; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error flag outside access");
    a_err_unmap: assert property (p_err_unmap) else $error("unmapped read not refused");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");
    a_lvl: assert property (p_lvl) else $error("state level wrong");
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped");
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt not held");
    a_pwm_rst: assert property (p_pwm_rst) else $error("output not idle");
    c_irq: cover property ($rose(IRQ_OUT));
    c_err: cover property (PSLVERR_OUT);
    c_pwm: cover property ($rose(PWM_OUT));
endmodule // prg_checker
bind prg_top prg_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PWM_OUT(PWM_OUT), .IRQ_OUT(IRQ_OUT));

/* dv/prg_lamp_model.sv */
// lamp stand-in: counts clock cycles during which the pulse output lights it
`timescale 1ns/1ps
module prg_lamp_model (
    input  wire        clk_in,
    input  wire        drive_in,
    input  wire        clr_in,
    output reg  [15:0] lit_out
);
    always @(posedge clk_in)
    begin
        if (clr_in)
            lit_out <= 16'h0;
        else if (drive_in)
            lit_out <= lit_out + 16'h1;
    end
endmodule // prg_lamp_model

/* dv/pwm_rhythm_generator_tb.sv */
// bench for the pulse generator: register access, duty, rhythm and interrupt
`timescale 1ns/1ps
`include "prg_regs.vh"
module pwm_rhythm_generator_tb;
    reg         mclk = 1'b0;
    reg         rstn = 1'b0;
    reg  [2:0]  src = 3'h0;
    reg         psel = 1'b0;
    reg         pen = 1'b0;
    reg         pwr = 1'b0;
    reg  [7:0]  pa = 8'h0;
    reg  [31:0] pwd = 32'h0;
    reg         lclr = 1'b0;
    reg  [31:0] q;
    reg         err;
    wire [31:0] prd;
    wire        prdy;
    wire        perr;
    wire        pwm;
    wire        irq;
    wire [15:0] lit;
    integer     failures = 0;
    integer     samples_checked = 0;
    integer     cyc = 0;
    integer     t0;
    always #4 mclk = ~mclk;
    // fast source rises every 2 clocks, slow one every 8
    always @(posedge mclk)
    begin
        src <= src + 3'h1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            test_done;
        end
    end
    prg_top #(.STEP_CYCLES(20)) u_dut (.MCLK_IN(mclk), .RSTN_IN(rstn), .SRC_FAST_IN(src[0]),
        .SRC_SLOW_IN(src[2]), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa),
        .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
        .PWM_OUT(pwm), .IRQ_OUT(irq));
    prg_lamp_model u_lamp (.clk_in(mclk), .drive_in(pwm), .clr_in(lclr), .lit_out(lit));
    task test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do @(posedge mclk); while (prdy !== 1'b1);
        q = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdchk(input string name, input [7:0] a, input [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, exp, q);
    endtask
    task wait_irq;
        do @(posedge mclk); while (irq !== 1'b1);
    endtask
    // cycle length 4 ticks; lamp window of 800 clocks spans whole periods of every mode
    task run(input [4:0] ctrl, input [11:0] div, input [12:0] duty, input [19:0] pat,
             input [15:0] exp);
        apb(`PRG_OFF_DIV, 1'b1, {20'h0, div});
        apb(`PRG_OFF_CYCLE, 1'b1, 32'h3);
        apb(`PRG_OFF_DUTY, 1'b1, {19'h0, duty});
        apb(`PRG_OFF_PATTERN, 1'b1, {12'h0, pat});
        apb(`PRG_OFF_CTRL, 1'b1, {27'h0, ctrl});
        repeat (40) @(posedge mclk);
        lclr <= 1'b1;
        @(posedge mclk);
        lclr <= 1'b0;
        repeat (801) @(posedge mclk);
        chk("lit cycles", {16'h0, exp}, {16'h0, lit});
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1 chk("idle output", 32'h1, pwm);
        chk("irq", 32'h0, irq);
        rdchk("ctrl", `PRG_OFF_CTRL, 32'h0);
        rdchk("div", `PRG_OFF_DIV, 32'h0);
        rdchk("cycle", `PRG_OFF_CYCLE, 32'hfff);
        rdchk("duty", `PRG_OFF_DUTY, 32'h0);
        rdchk("pattern", `PRG_OFF_PATTERN, 32'hfffff);
        rdchk("imask", `PRG_OFF_IMASK, 32'h0);
        apb(8'h20, 1'b1, 32'h5a);
        rdchk("unmapped", 8'h20, 32'h0);
        chk("slverr", 32'h1, err);
        run(5'h05, 12'h0, 13'h1, 20'hfffff, 16'd200);
        run(5'h05, 12'h0, 13'h0, 20'hfffff, 16'd0);
        run(5'h05, 12'h0, 13'h4, 20'hfffff, 16'd800);
        run(5'h01, 12'h0, 13'h1, 20'hfffff, 16'd600);
        run(5'h07, 12'h0, 13'h2, 20'hfffff, 16'd400);
        run(5'h05, 12'h1, 13'h1, 20'hfffff, 16'd200);
        run(5'h15, 12'h0, 13'h4, 20'h00000, 16'd0);
        run(5'h15, 12'h0, 13'h4, 20'h55555, 16'd400);
        run(5'h1d, 12'h0, 13'h0, 20'h00000, 16'd800);
        apb(`PRG_OFF_CTRL, 1'b1, 32'h0);
        apb(`PRG_OFF_CTRL, 1'b1, 32'h15);
        apb(`PRG_OFF_STATE, 1'b0, 32'h0);
        chk("first step", 32'h13, q & 32'h1f);
        apb(`PRG_OFF_STATUS, 1'b0, 32'h0);
        apb(`PRG_OFF_IMASK, 1'b1, 32'h1);
        wait_irq;
        t0 = cyc;
        rdchk("status", `PRG_OFF_STATUS, 32'h1);
        @(posedge mclk);
        #1 chk("irq cleared", 32'h0, irq);
        wait_irq;
        chk("event period", 32'd400, cyc - t0);
        apb(`PRG_OFF_IMASK, 1'b1, 32'h0);
        repeat (420) @(posedge mclk);
        chk("irq masked", 32'h0, irq);
        rdchk("sticky", `PRG_OFF_STATUS, 32'h1);
        rdchk("read clear", `PRG_OFF_STATUS, 32'h0);
        test_done;
    end
endmodule // pwm_rhythm_generator_tb
